/* File: hw/baud_gen_regs.svh */
// register offsets, field positions, reset values and divisor constants
`ifndef BAUD_GEN_REGS_SVH
`define BAUD_GEN_REGS_SVH
`define RATE_DIV_OFFSET    8'h00
`define FINE_PRE_OFFSET    8'h04
`define GEN_STATUS_OFFSET  8'h08
`define RATE_DIV_RESET     8'h00
`define FINE_PRE_RESET     8'h00
`define TX_LEN_BIT         7
`define RX_FILT_BIT        6
`define BPS_HI_BIT         5
`define BPS_LO_BIT         4
`define POW_SEL_HI         2
`define COARSE_SEL_HI      7
`define COARSE_SEL_LO      5
`define INSERT_HI          4
`define BPD_DIV_0          4'h1
`define BPD_DIV_1          4'h3
`define BPD_DIV_2          4'h4
`define BPD_DIV_3          4'hD
`define FRAME_LEN          32
`define RT_PER_BIT         64
`define RT_SUB_MASK        6'h03
`define BRK_NORMAL         4'hA
`define BRK_RX_LONG        4'hB
`define BRK_TX_LONG        4'hD
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

/* File: hw/baud_gen_pkg.sv */
// types shared by the baud generator: bus carriers and the state record
package baud_gen_pkg;
  // master to slave half of the register bus
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_type;
  // slave to master half of the register bus
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;
  // every flip-flop of the generator except the two reset stages
  typedef struct packed {
    logic [7:0]  rate_reg;
    logic [7:0]  fine_reg;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [3:0]  pre_cnt;
    logic [4:0]  frame_cnt;
    logic [4:0]  acc;
    logic        stretch;
    logic        pre_tick;
    logic [3:0]  bpd_cnt;
    logic        bpd_tick;
    logic [6:0]  pow_cnt;
    logic        pow_tick;
    logic [5:0]  rt_cnt;
    logic        rt_tick;
    logic        bit_tick;
    logic [3:0]  rx_len;
    logic [3:0]  tx_len;
  } state_type;
endpackage

/* File: hw/baud_gen.sv */
// baud-rate generator with break-length control, registers on AXI4-Lite
`include "baud_gen_regs.svh"
// Overview of operation
// RL1: filter on: detect break after 11/12 bits
// RL2: lengthen on: send break of 13/14 bits
// RL3: both set: both lengthened lengths together
// RL4: filter bit RW, reset clear; else normal
// RL5: filter rejects 10.35-bit zero characters
// RL6: baud prescale codes give 1,3,4,13
// RL7: power divisor is two to field value
// RL8: coarse code 0 bypass, else 2..8
// RL9: coarse bypass also skips fine adjust
// RL10: software avoids bypass switch while enabled
// RL11: insert N clocks per 32-output frame
// RL12: rate is source over 64*BAUD_PRESCALE_DIVISOR*BD*(PD+FINE_ADJUST_FRACTION)
// RL13: source is bus or oscillator clock
// RL14: one rate shared by receiver, transmitter
// RL15: lengthen bit RW, reset clear, selects
// RL16: inserted clocks spread evenly over frame
module baud_gen
  import baud_gen_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire axi_req_type axi_req,
  output axi_rsp_type      axi_rsp,
  input  wire logic        osc_tick,
  input  wire logic        baud_clock_source_select,
  input  wire logic        char_length_ninth,
  output logic             rt_tick,
  output logic             bit_tick,
  output logic [3:0]       rx_break_bits,
  output logic [3:0]       tx_break_bits
);

  logic      rst_meta_n;  // first reset stage, read only by second
  logic      rst_n;       // released reset used everywhere
  state_type r_reg;       // registered state
  state_type r_next;      // next state

  // combinational helpers
  logic       src_tick;    // one source clock edge
  logic       bypass;      // coarse and fine stages skipped
  logic [2:0] coarse_sel;  // coarse prescale select field
  logic [4:0] insert_cnt;  // clock insert count field
  logic [1:0] bps_sel;     // baud prescale select
  logic [2:0] pow_sel;     // power of two select
  logic [3:0] bpd_div;     // baud prescale divisor
  logic [6:0] pow_mask;    // power divisor minus one
  logic [3:0] pre_limit;   // coarse terminal count
  logic [5:0] acc_sum;     // fine adjust accumulator with carry
  logic       cfg_write;   // divider register written this cycle
  logic       do_write;    // both write halves present
  logic [7:0] rd_val;      // read mux result
  logic       rd_ok;       // read address mapped

  // reset released through two flops; assert is asynchronous
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // field extraction
  assign coarse_sel = r_reg.fine_reg[`COARSE_SEL_HI:`COARSE_SEL_LO];
  assign insert_cnt = r_reg.fine_reg[`INSERT_HI:0];
  assign bps_sel    = r_reg.rate_reg[`BPS_HI_BIT:`BPS_LO_BIT];
  assign pow_sel    = r_reg.rate_reg[`POW_SEL_HI:0];
  assign bypass     = (coarse_sel == 3'h0);  // RL9

  // source is every bus clock or the oscillator tick
  assign src_tick = baud_clock_source_select ? osc_tick : 1'b1;  // RL13

  // write lands when address and data are both held
  assign do_write  = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  assign cfg_write = do_write && r_reg.w_lane0 &&
                     (r_reg.aw_addr[7:2] == 6'(`RATE_DIV_OFFSET >> 2) ||
                      r_reg.aw_addr[7:2] == 6'(`FINE_PRE_OFFSET >> 2));

  // divisor lookups
  always_comb
  begin
    case (bps_sel)  // RL6
      2'h0:    bpd_div = `BPD_DIV_0;
      2'h1:    bpd_div = `BPD_DIV_1;
      2'h2:    bpd_div = `BPD_DIV_2;
      default: bpd_div = `BPD_DIV_3;
    endcase
    pow_mask  = 7'((8'h01 << pow_sel) - 8'h01);  // RL7
    // coarse divisor is code+1; a stretched period adds one
    pre_limit = {1'b0, coarse_sel} + {3'h0, r_reg.stretch};  // RL8 RL11
    acc_sum   = {1'b0, r_reg.acc} + {1'b0, insert_cnt};
  end

  // read mux; status shows live divider state
  always_comb
  begin
    rd_ok = 1'b1;
    case (axi_req.araddr[7:2])
      6'(`RATE_DIV_OFFSET >> 2):  rd_val = r_reg.rate_reg;
      6'(`FINE_PRE_OFFSET >> 2):  rd_val = r_reg.fine_reg;
      6'(`GEN_STATUS_OFFSET >> 2):
        rd_val = {baud_clock_source_select, bypass, r_reg.stretch,
                  r_reg.frame_cnt};
      default:
      begin
        rd_val = 8'h00;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // next-state logic: bus slave, divider chain, break lengths
  always_comb
  begin
    r_next          = r_reg;
    r_next.pre_tick = 1'b0;
    r_next.bpd_tick = 1'b0;
    r_next.pow_tick = 1'b0;
    r_next.rt_tick  = 1'b0;
    r_next.bit_tick = 1'b0;

    // address and data accepted in either order
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      r_next.aw_held = 1'b1;
      r_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      r_next.w_held  = 1'b1;
      r_next.w_data  = axi_req.wdata[7:0];
      r_next.w_lane0 = axi_req.wstrb[0];
    end
    if (do_write)
    begin
      r_next.aw_held = 1'b0;
      r_next.w_held  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = `RESP_OKAY;
      case (r_reg.aw_addr[7:2])
        6'(`RATE_DIV_OFFSET >> 2):
          if (r_reg.w_lane0)
            r_next.rate_reg = r_reg.w_data;  // RL15 RL4
        6'(`FINE_PRE_OFFSET >> 2):
          if (r_reg.w_lane0)
            r_next.fine_reg = r_reg.w_data;
        6'(`GEN_STATUS_OFFSET >> 2): ;  // read-only, write dropped
        default: r_next.bresp = `RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && axi_req.bready)
      r_next.bvalid = 1'b0;

    // reads answer one cycle after the address
    if (axi_req.arvalid && axi_rsp.arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = rd_val;
      r_next.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (r_reg.rvalid && axi_req.rready)
      r_next.rvalid = 1'b0;

    // coarse prescaler with fractional insertion
    if (src_tick)
    begin
      if (bypass)
        r_next.pre_tick = 1'b1;  // RL9
      else if (r_reg.pre_cnt >= pre_limit)
      begin
        r_next.pre_cnt   = 4'h0;
        r_next.pre_tick  = 1'b1;
        r_next.frame_cnt = r_reg.frame_cnt + 5'h01;  // RL11
        // accumulator carry spaces inserted clocks evenly
        r_next.acc       = acc_sum[4:0];  // RL16
        r_next.stretch   = acc_sum[5];  // RL11
      end
      else
        r_next.pre_cnt = r_reg.pre_cnt + 4'h1;
    end

    // baud prescaler
    if (r_reg.pre_tick)
    begin
      if (r_reg.bpd_cnt >= bpd_div - 4'h1)
      begin
        r_next.bpd_cnt  = 4'h0;
        r_next.bpd_tick = 1'b1;  // RL6
      end
      else
        r_next.bpd_cnt = r_reg.bpd_cnt + 4'h1;
    end

    // power of two divider
    if (r_reg.bpd_tick)
    begin
      if (r_reg.pow_cnt >= pow_mask)
      begin
        r_next.pow_cnt  = 7'h00;
        r_next.pow_tick = 1'b1;  // RL7
      end
      else
        r_next.pow_cnt = r_reg.pow_cnt + 7'h01;
    end

    // fixed divide by 64: sample ticks every 4, bit tick every 64
    if (r_reg.pow_tick)
    begin
      r_next.rt_cnt   = r_reg.rt_cnt + 6'h01;  // RL12
      r_next.rt_tick  = (r_reg.rt_cnt & `RT_SUB_MASK) == `RT_SUB_MASK;
      r_next.bit_tick = r_reg.rt_cnt == 6'(`RT_PER_BIT - 1);  // RL14
    end

    // new settings restart the chain so no count overshoots
    if (cfg_write)
    begin
      r_next.pre_cnt   = 4'h0;
      r_next.frame_cnt = 5'h00;
      r_next.acc       = 5'h00;
      r_next.stretch   = 1'b0;
      r_next.bpd_cnt   = 4'h0;
      r_next.pow_cnt   = 7'h00;
      r_next.rt_cnt    = 6'h00;
    end

    // break lengths; 11 bits exceeds a 10.35-bit zero character
    if (r_reg.rate_reg[`RX_FILT_BIT])
      r_next.rx_len = `BRK_RX_LONG + {3'h0, char_length_ninth};  // RL1 RL3 RL5
    else
      r_next.rx_len = `BRK_NORMAL + {3'h0, char_length_ninth};  // RL4
    if (r_reg.rate_reg[`TX_LEN_BIT])
      r_next.tx_len = `BRK_TX_LONG + {3'h0, char_length_ninth};  // RL2 RL3
    else
      r_next.tx_len = `BRK_NORMAL + {3'h0, char_length_ninth};  // RL4
  end

  // state register; bypass switching glitch is the caller's care (RL10)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg          <= '0;
      r_reg.rate_reg <= `RATE_DIV_RESET;
      r_reg.fine_reg <= `FINE_PRE_RESET;
      r_reg.rx_len   <= `BRK_NORMAL;
      r_reg.tx_len   <= `BRK_NORMAL;
    end
    else
      r_reg <= r_next;
  end

  // bus outputs; ready while the holding slot is free and no response is pending
  always_comb
  begin
    axi_rsp.awready = !r_reg.aw_held && !r_reg.bvalid;
    axi_rsp.wready  = !r_reg.w_held && !r_reg.bvalid;
    axi_rsp.bvalid  = r_reg.bvalid;
    axi_rsp.bresp   = r_reg.bresp;
    axi_rsp.arready = !r_reg.rvalid;
    axi_rsp.rvalid  = r_reg.rvalid;
    axi_rsp.rdata   = {24'h000000, r_reg.rdata};
    axi_rsp.rresp   = r_reg.rresp;
  end

  // shared rate outputs to receiver and transmitter
  assign rt_tick       = r_reg.rt_tick;
  assign bit_tick      = r_reg.bit_tick;
  assign rx_break_bits = r_reg.rx_len;
  assign tx_break_bits = r_reg.tx_len;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // receive break length from filter and character length
  a_rx_filter_len: assert property ( // RL1
    (r_reg.rate_reg[`RX_FILT_BIT] && !r_reg.rate_reg[`TX_LEN_BIT])
      |=> rx_break_bits == $past(char_length_ninth ? 4'hC : 4'hB))
    else $error("rx break length wrong with filter set");
  // transmit break length from lengthen bit
  a_tx_long_len: assert property ( // RL2
    (r_reg.rate_reg[`TX_LEN_BIT] && !r_reg.rate_reg[`RX_FILT_BIT])
      |=> tx_break_bits == $past(char_length_ninth ? 4'hE : 4'hD))
    else $error("tx break length wrong with lengthen set");
  // both set gives both long lengths
  a_both_long: assert property ( // RL3
    (r_reg.rate_reg[7:6] == 2'h3 && char_length_ninth)
      |=> (rx_break_bits == 4'hC && tx_break_bits == 4'hE))
    else $error("combined break lengths wrong");
  // both clear gives normal lengths
  a_normal_len: assert property ( // RL4
    (r_reg.rate_reg[7:6] == 2'h0 && !char_length_ninth)
      |=> (rx_break_bits == 4'hA && tx_break_bits == 4'hA))
    else $error("normal break lengths wrong");
  // bypass passes each source tick straight on
  a_bypass_pass: assert property ( // RL9
    (bypass && src_tick) |=> r_reg.pre_tick)
    else $error("bypass did not pass source tick");
  // coarse code 1 without insertion divides by two
  a_coarse_two: assert property ( // RL8
    (r_reg.pre_tick && r_reg.fine_reg == 8'h20 && !baud_clock_source_select
      && !cfg_write && !r_reg.stretch)
      |=> !r_reg.pre_tick ##1 r_reg.pre_tick)
    else $error("coarse divide by two period wrong");
  // baud prescale count stays under thirteen
  a_bpd_bound: assert property ( // RL6
    r_reg.bpd_cnt <= 4'hC)
    else $error("baud prescale count overran");
  // power divider count stays at or below its mask
  a_pow_bound: assert property ( // RL7
    r_reg.pow_cnt <= 7'h7F && (r_reg.pow_cnt <= pow_mask || $past(cfg_write)))
    else $error("power divider count overran");
  // a bit tick always coincides with a sample tick
  a_bit_on_rt: assert property ( // RL14
    bit_tick |-> rt_tick)
    else $error("bit tick without sample tick");
  // frame advances only on a coarse output tick
  a_frame_step: assert property ( // RL11
    (r_reg.frame_cnt != $past(r_reg.frame_cnt) && !$past(cfg_write))
      |-> r_reg.pre_tick)
    else $error("frame count moved without prescaler output");
  // a held-off source leaves the coarse count alone
  a_src_hold: assert property ( // RL13
    (baud_clock_source_select && !osc_tick && !cfg_write)
      |=> ($stable(r_reg.pre_cnt) && !r_reg.pre_tick))
    else $error("coarse stage moved without a source tick");
  // a stretched period only starts with a coarse output
  a_stretch_start: assert property ( // RL11
    (r_reg.stretch && !$past(r_reg.stretch)) |-> r_reg.pre_tick)
    else $error("stretch began without prescaler output");

endmodule

/* File: test/test_sci_baud_generator_lin_break.sv */
// self-checking bench for the baud generator and break-length control
`include "baud_gen_regs.svh"
module test_sci_baud_generator_lin_break
  import baud_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;          // 100 MHz bus clock
  logic        resetn;       // active-low reset
  axi_req_type req;          // bench side of the register bus
  axi_rsp_type rsp;          // design side of the register bus
  logic        osc_tick = 1'b0; // oscillator enable pulse, every third clock
  logic [1:0]  osc_cnt = 2'h0;  // divides the bus clock for the oscillator pulse
  logic        src_sel;      // baud source select
  logic        ninth;        // character-length bit
  logic        rt_tick;      // 16x rate pulse
  logic        bit_tick;     // 1x rate pulse
  logic [3:0]  rx_bits;      // break detect length
  logic [3:0]  tx_bits;      // break generate length
  int          bad_count;    // mismatches seen
  int          total_checks; // comparisons made
  int          cycles = 0;   // timeout counter
  logic [31:0] rd;           // read data
  logic [1:0]  rs;           // response code
  logic [7:0]  ra;           // random rate value
  logic [7:0]  fa;           // random fine value

  baud_gen dut_u (
    .clk                      (clk),
    .resetn                   (resetn),
    .axi_req                  (req),
    .axi_rsp                  (rsp),
    .osc_tick                 (osc_tick),
    .baud_clock_source_select (src_sel),
    .char_length_ninth        (ninth),
    .rt_tick                  (rt_tick),
    .bit_tick                 (bit_tick),
    .rx_break_bits            (rx_bits),
    .tx_break_bits            (tx_bits)
  );

  // free-running clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // oscillator stand-in: a pulse every third clock keeps periods exact
  always @(posedge clk)
  begin
    osc_cnt  <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    osc_tick <= (osc_cnt == 2'h2);
  end

  // hang guard, sized well above the longest measured period set
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // look at the handshake before the edge, act just after it
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    do
    begin
      @(negedge clk);
      aw_t = req.awvalid & rsp.awready;
      w_t  = req.wvalid & rsp.wready;
      b_t  = rsp.bvalid;
      r    = rsp.bresp;
      @(posedge clk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
    end while (b_t !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(negedge clk);
      ar_t = req.arvalid & rsp.arready;
      r_t  = rsp.rvalid;
      d    = rsp.rdata;
      r    = rsp.rresp;
      @(posedge clk);
      if (ar_t) req.arvalid <= 1'b0;
    end while (r_t !== 1'b1);
    req.rready <= 1'b0;
  endtask

  // exact clocks per bit: 64 outputs of the coarse stage hold N*2 insertions
  function automatic int bit_len(logic [7:0] rate, logic [7:0] fine, int src);
    int baud_prescale_divisor;
    int bd;
    baud_prescale_divisor = (rate[5:4] == 2'h0) ? 1 : (rate[5:4] == 2'h1) ? 3 : (rate[5:4] == 2'h2) ? 4 : 13;
    bd  = 1 << rate[2:0];
    if (fine[7:5] == 3'h0) return 64 * baud_prescale_divisor * bd * src;
    return 2 * baud_prescale_divisor * bd * (32 * (fine[7:5] + 1) + fine[4:0]) * src;
  endfunction

  // the first bit after a register write is partial, so time the second
  task automatic rate_case(input logic [7:0] rate, input logic [7:0] fine, input logic src);
    int n;
    int rts;
    @(posedge clk);
    src_sel <= src;
    axi_write(`RATE_DIV_OFFSET, rate, 4'h1, rs);
    axi_write(`FINE_PRE_OFFSET, fine, 4'h1, rs);
    do @(negedge clk); while (bit_tick !== 1'b1);
    n   = 0;
    rts = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (rt_tick === 1'b1) rts++;
    end while (bit_tick !== 1'b1);
    check(n, bit_len(rate, fine, src ? 3 : 1));
    check(rts, 16);
  endtask

  initial
  begin
    req          = '0;
    resetn       = 1'b0;
    src_sel      = 1'b0;
    ninth        = 1'b0;
    bad_count    = 0;
    total_checks = 0;
    void'($urandom(72447));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state of both registers and break lengths
    axi_read(`RATE_DIV_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    axi_read(`FINE_PRE_OFFSET, rd, rs);
    check(rd, 32'h00000000);
    check(32'(rx_bits), 32'h0000000A);
    check(32'(tx_bits), 32'h0000000A);
    // status after reset: bus source, coarse bypass, frame at zero
    axi_read(`GEN_STATUS_OFFSET, rd, rs);
    check(rd, 32'h00000040);
    // unmapped place answers with an error and no data
    axi_write(8'h0C, 8'h5A, 4'h1, rs);
    check(32'(rs), 32'h00000002);
    axi_read(8'h0C, rd, rs);
    check(32'(rs), 32'h00000002);
    check(rd, 32'h00000000);
    // random read-back of every field, then a write with lane 0 masked
    repeat (6)
    begin
      ra = 8'($urandom);
      fa = 8'($urandom);
      axi_write(`RATE_DIV_OFFSET, ra, 4'h1, rs);
      axi_write(`FINE_PRE_OFFSET, fa, 4'h1, rs);
      check(32'(rs), 32'h00000000);
      axi_read(`RATE_DIV_OFFSET, rd, rs);
      check(rd, {24'h000000, ra});
      axi_read(`FINE_PRE_OFFSET, rd, rs);
      check(rd, {24'h000000, fa});
    end
    axi_write(`FINE_PRE_OFFSET, ~fa, 4'hE, rs);
    axi_read(`FINE_PRE_OFFSET, rd, rs);
    check(rd, {24'h000000, fa});
    // every combination of the two break bits and character length
    for (int i = 0; i < 8; i++)
    begin
      axi_write(`RATE_DIV_OFFSET, {i[2], i[1], 6'h00}, 4'h1, rs);
      @(posedge clk);
      ninth <= i[0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(32'(rx_bits), 32'(i[1] ? (i[0] ? 4'hC : 4'hB) : (i[0] ? 4'hB : 4'hA)));
      check(32'(tx_bits), 32'(i[2] ? (i[0] ? 4'hE : 4'hD) : (i[0] ? 4'hB : 4'hA)));
    end
    // corner rates: bypass ignores insertion, largest divisors, oscillator source
    rate_case(8'h07, 8'h1F, 1'b0);
    rate_case(8'h30, 8'h00, 1'b0);
    rate_case(8'h20, 8'hFF, 1'b0);
    rate_case(8'h10, 8'h23, 1'b1);
    rate_case(8'h00, 8'h20, 1'b0);
    // random rates kept short enough for the run length
    repeat (5)
    begin
      ra = 8'($urandom);
      fa = 8'($urandom);
      rate_case({ra[7:5], 1'b0, ra[3], 2'h0, ra[0]}, fa, 1'b0);
    end
    report_and_stop();
  end
endmodule
